// ### verilog/fsv_ctrl.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fsv_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pdebug_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Nonvolatile contents
	input wire logic [7:0] nv_option_byte_i,
	input wire logic [7:0] nv_protection_byte_i,
	input wire logic [63:0] backdoor_key_bytes_i,
	// Background pin strap and requests
	input wire logic background_mode_pin_i,
	input wire logic bgnd_req_i,
	output logic bgnd_active_o,
	// Bus access from CPU or debug
	input wire logic acc_valid_i,
	input wire logic acc_write_i,
	input wire logic [15:0] acc_addr_i,
	input wire logic [7:0] acc_wdata_i,
	input wire logic acc_vector_i,
	input wire logic acc_secure_code_i,
	input wire logic acc_ram_code_i,
	input wire logic acc_debug_i,
	// Memory side
	output logic mem_req_o,
	output logic mem_write_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	input wire logic [7:0] mem_rdata_i,
	output logic [7:0] acc_rdata_o,
	output logic acc_blocked_o,
	// Flash command events
	input wire logic fcmd_wr_i,
	input wire logic [7:0] fcmd_code_i,
	input wire logic fcmd_debug_i,
	input wire logic blank_ok_i,
	// Status
	output logic secure_o,
	output logic debug_en_o
);
	import fsv_pkg::*;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		fsv_state_t state;
		logic [7:0] opt;
		logic [7:0] prot;
		logic key_acc;
		logic [7:0] key_seen;
		logic unsec;
		logic unlock_ev;
		logic strap_low;
		logic acc_err;
		logic dbg_req;
		logic bgnd;
		logic [3:0] cmp_idx;
		logic cmp_ok;
		logic [31:0] prdata;
		logic mreq;
		logic mwr;
		logic [15:0] maddr;
		logic [7:0] mwdata;
		logic blk;
		logic blk_d;
		logic [7:0] rdata;
	} fsv_ctrl_t;

	fsv_ctrl_t s_reg;
	fsv_ctrl_t s_next;

	logic secure;
	logic redir;
	logic in_flash;
	logic in_ram;
	logic in_vec;
	logic in_key;
	logic key_wr;
	logic [7:0] key_rdata;
	logic [7:0] nv_key;
	logic apb_wr;
	logic apb_setup;
	logic mapped;

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	// Security from the working option field and the volatile unlock
	assign secure = (s_reg.opt[1:0] != SEC_OPEN) && !s_reg.unsec;
	// Redirect needs the no-redirect and protection disable bits clear and a partial protected region
	// A last unprotected address of all ones means nothing is protected
	assign redir = !s_reg.opt[OPT_NORED_BIT] && !s_reg.prot[PROT_DIS_BIT]
		&& ({s_reg.prot[7:1], 9'h1FF} >= FLASH_LO)
		&& ({s_reg.prot[7:1], 9'h1FF} != 16'hFFFF);
	// Region decode of the incoming access
	assign in_flash = acc_addr_i >= FLASH_LO;
	assign in_ram = (acc_addr_i >= RAM_LO) && (acc_addr_i <= RAM_HI);
	assign in_vec = (acc_addr_i >= VEC_LO) && (acc_addr_i <= VEC_HI);
	assign in_key = (acc_addr_i[15:3] == KEY_BASE_ADDR[15:3]);
	// Key capture only with key access on, in ST_RUN, and from non-debug code in RAM
	assign key_wr = acc_valid_i && acc_write_i && in_key && s_reg.key_acc
		&& acc_ram_code_i && !acc_debug_i && s_reg.state == ST_RUN;
	// Stored byte for the read port, which lags the index by one; the 3-bit index wraps so count 8 meets byte 7
	assign nv_key = backdoor_key_bytes_i[{s_reg.cmp_idx[2:0] - 3'h1, 3'h0} +: 8];
	// APB phases
	assign apb_setup = psel_i && !penable_i;
	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign mapped = (paddr_i == OFS_OPTION) || (paddr_i == OFS_PROT) || (paddr_i == OFS_CONFIG)
		|| (paddr_i == OFS_STATUS) || (paddr_i == OFS_DEBUG);

	// ------------------------------------------------------------------------
	// Key store
	// ------------------------------------------------------------------------
	fsv_key_mem u_key_mem (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.wr_i(key_wr),
		.waddr_i(acc_addr_i[2:0]),
		.wdata_i(acc_wdata_i),
		.raddr_i(s_reg.cmp_idx[2:0]),
		.rdata_o(key_rdata)
	);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	// Load, access filter, registers and key compare
	always_comb begin
		s_next = s_reg;
		s_next.unlock_ev = 1'b0;
		case (s_reg.state)
			ST_LOAD: begin
				// Working copies and the strap are caught after reset release
				s_next.opt = nv_option_byte_i;
				s_next.prot = nv_protection_byte_i;
				s_next.strap_low = !background_mode_pin_i;
				s_next.state = ST_RUN;
			end
			ST_RUN: begin
				if (key_wr) begin
					s_next.key_seen[acc_addr_i[2:0]] = 1'b1;
				end
			end
			ST_CMP: begin
				// Read port lags the index by one cycle
				if (s_reg.cmp_idx != 4'h0 && key_rdata != nv_key) begin
					s_next.cmp_ok = 1'b0;
				end
				if (s_reg.cmp_idx == 4'h8) begin
					if (s_next.cmp_ok && s_reg.opt[OPT_BACKDOOR_ENABLE_BIT]) begin
						s_next.unsec = 1'b1;
						s_next.unlock_ev = 1'b1;
					end
					s_next.cmp_idx = 4'h0;
					s_next.state = ST_RUN;
				end else begin
					s_next.cmp_idx = s_reg.cmp_idx + 4'h1;
				end
			end
			default: begin
				s_next.state = ST_LOAD;
			end
		endcase
		// Access filter and vector redirect
		s_next.mreq = acc_valid_i && s_reg.state != ST_LOAD;
		s_next.mwr = acc_write_i && !(in_key && s_reg.key_acc);
		s_next.maddr = acc_addr_i;
		if (redir && acc_vector_i && in_vec) begin
			s_next.maddr = {s_reg.prot[7:1], acc_addr_i[PAGE_BITS-1:0]};
		end
		s_next.mwdata = acc_wdata_i;
		// Only flash and RAM are guarded; page registers fall outside
		s_next.blk = acc_valid_i && secure && (in_flash || in_ram)
			&& (acc_debug_i || !acc_secure_code_i);
		if (s_next.blk) begin
			s_next.mreq = 1'b0;
		end
		s_next.blk_d = s_reg.blk;
		s_next.rdata = s_reg.blk_d ? 8'h00 : mem_rdata_i;
		// Blank flash check lifts security
		if (blank_ok_i) begin
			s_next.unsec = 1'b1;
			s_next.unlock_ev = 1'b1;
		end
		// Debug program or erase while secure is an access error
		if (apb_wr && paddr_i == OFS_STATUS && pwdata_i[ST_ACCERR_BIT]) begin
			s_next.acc_err = 1'b0;
		end
		if (fcmd_wr_i && fcmd_debug_i && secure && (fcmd_code_i == CMD_BYTE_PROG
			|| fcmd_code_i == CMD_BURST_PROG || fcmd_code_i == CMD_PAGE_ERASE)) begin
			s_next.acc_err = 1'b1;
		end
		// Register writes
		if (apb_wr && s_reg.state == ST_RUN) begin
			case (paddr_i)
				OFS_PROT: begin
					if (pdebug_i) begin
						s_next.prot = pwdata_i[7:0];
					end
				end
				OFS_CONFIG: begin
					s_next.key_acc = pwdata_i[CFG_KEY_ACCESS_MODE_BIT];
					if (s_reg.key_acc && !pwdata_i[CFG_KEY_ACCESS_MODE_BIT]) begin
						s_next.state = ST_CMP;
						s_next.cmp_idx = 4'h0;
						s_next.cmp_ok = &s_reg.key_seen;
						s_next.key_seen = 8'h00;
					end
				end
				OFS_DEBUG: begin
					s_next.dbg_req = pwdata_i[0];
				end
				default: begin
				end
			endcase
		end
		// Background mode: free when open, strap only while secure
		s_next.bgnd = secure ? s_reg.strap_low : (s_reg.bgnd || bgnd_req_i);
		// Read data captured in the setup phase
		s_next.prdata = 32'h0000_0000;
		if (apb_setup) begin
			case (paddr_i)
				OFS_OPTION: s_next.prdata = {24'h00_0000, s_reg.opt[7:6], 4'h0, s_reg.opt[1:0]};
				OFS_PROT: s_next.prdata = {24'h00_0000, s_reg.prot};
				OFS_CONFIG: s_next.prdata = {26'h000_0000, s_reg.key_acc, 5'h00};
				OFS_STATUS: s_next.prdata = {27'h000_0000, s_reg.bgnd, s_reg.unsec, s_reg.acc_err, redir, secure};
				OFS_DEBUG: s_next.prdata = {31'h0000_0000, s_reg.dbg_req && !secure};
				default: s_next.prdata = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_reg <= '0;
			s_reg.state <= ST_LOAD;
			s_reg.opt <= OPT_RST;
			s_reg.prot <= PROT_RST;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign prdata_o = s_reg.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign mem_req_o = s_reg.mreq;
	assign mem_write_o = s_reg.mwr;
	assign mem_addr_o = s_reg.maddr;
	assign mem_wdata_o = s_reg.mwdata;
	assign acc_rdata_o = s_reg.rdata;
	assign acc_blocked_o = s_reg.blk;
	assign secure_o = secure;
	assign debug_en_o = s_reg.dbg_req && !secure;
	assign bgnd_active_o = s_reg.bgnd;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence key_clear_s;
		ce_i && s_reg.state == ST_RUN && apb_wr && paddr_i == OFS_CONFIG
			&& s_reg.key_acc && !pwdata_i[CFG_KEY_ACCESS_MODE_BIT];
	endsequence
	sequence cmp_run_s;
		s_reg.state == ST_CMP [*8];
	endsequence

	debug_refuse_a: assert property (secure |-> !debug_en_o)
		else $error("debug enabled while secure");
	sec_field_a: assert property (s_reg.state != ST_LOAD && !s_reg.unsec
		|-> secure == !(s_reg.opt[1] && !s_reg.opt[0]))
		else $error("security field decode wrong");
	block_access_a: assert property (ce_i && acc_valid_i && secure && in_ram && acc_debug_i
		|=> acc_blocked_o && !mem_req_o ##1 1'b1 ##1 (!$past(ce_i) || acc_rdata_o == 8'h00 || !$past(ce_i, 2)))
		else $error("secure access not blocked");
	secure_code_a: assert property (ce_i && acc_valid_i && acc_secure_code_i && !acc_debug_i
		|=> !acc_blocked_o)
		else $error("secure code blocked");
	page_open_a: assert property (ce_i && acc_valid_i && !in_flash && !in_ram |=> !acc_blocked_o)
		else $error("page register access blocked");
	redirect_a: assert property (ce_i && acc_valid_i && acc_vector_i && acc_addr_i == 16'hFFFE
		&& !s_next.blk |=> mem_addr_o == 16'hFFFE)
		else $error("reset vector redirected");
	vec_move_a: assert property (ce_i && acc_valid_i && acc_vector_i && in_vec && redir
		|=> mem_addr_o[15:9] == $past(s_reg.prot[7:1]) && mem_addr_o[8:0] == $past(acc_addr_i[8:0]))
		else $error("vector not redirected");
	prot_write_a: assert property (ce_i && apb_wr && paddr_i == OFS_PROT && !pdebug_i
		|=> $stable(s_reg.prot))
		else $error("protection written by software");
	key_cmp_a: assert property (key_clear_s ##1 (ce_i throughout cmp_run_s) ##1 ce_i
		|=> s_reg.state == ST_RUN && s_reg.cmp_idx == 4'h0
		&& (s_reg.unsec || !s_reg.opt[OPT_BACKDOOR_ENABLE_BIT] || !s_reg.cmp_ok))
		else $error("key compare did not finish");
	key_gate_a: assert property (ce_i && s_reg.state == ST_CMP && s_reg.cmp_idx == 4'h8
		&& !s_reg.opt[OPT_BACKDOOR_ENABLE_BIT] && !s_reg.unsec && !blank_ok_i |=> !s_reg.unsec)
		else $error("key unlocked with backdoor off");
	blank_a: assert property (ce_i && blank_ok_i |=> !secure)
		else $error("blank check left device secure");
	acc_err_a: assert property (ce_i && fcmd_wr_i && fcmd_debug_i && secure
		&& fcmd_code_i == CMD_PAGE_ERASE |=> s_reg.acc_err)
		else $error("debug erase not flagged");
	key_no_cmd_a: assert property (ce_i && acc_valid_i && acc_write_i && in_key && s_reg.key_acc
		&& !s_next.blk |=> mem_req_o && !mem_write_o)
		else $error("key write reached flash");
	load_a: assert property ($rose(s_reg.state == ST_RUN) && $past(s_reg.state) == ST_LOAD
		|-> s_reg.opt == $past(nv_option_byte_i))
		else $error("option byte not loaded");
	unsec_reset_a: assert property (s_reg.state == ST_LOAD |-> !s_reg.unsec)
		else $error("unlock survived reset");
	ram_only_a: assert property (acc_valid_i && acc_write_i && !acc_ram_code_i |-> !key_wr)
		else $error("key taken from non-RAM code");
	strap_a: assert property (secure && s_reg.state == ST_RUN && ce_i |=> bgnd_active_o == $past(s_reg.strap_low))
		else $error("background entered while secure");
endmodule : fsv_ctrl
`default_nettype wire

// ### inc/fsv_pkg.sv
// ----------------------------------------------------------------------------
// Flash security and vector redirect constants
// ----------------------------------------------------------------------------
package fsv_pkg;
	// Nonvolatile byte locations in the flash map
	localparam logic [15:0] NV_PROT_ADDR = 16'hFFBD;
	localparam logic [15:0] NV_OPT_ADDR = 16'hFFBF;
	localparam logic [15:0] KEY_BASE_ADDR = 16'hFFB0;
	localparam int KEY_BYTES = 8;
	// Memory map regions
	localparam logic [15:0] FLASH_LO = 16'hC000;
	localparam logic [15:0] RAM_LO = 16'h0080;
	localparam logic [15:0] RAM_HI = 16'h087F;
	localparam logic [15:0] VEC_LO = 16'hFFC0;
	localparam logic [15:0] VEC_HI = 16'hFFFD;
	localparam int PAGE_BITS = 9;
	// Option and protection byte fields
	localparam int OPT_BACKDOOR_ENABLE_BIT = 7;
	localparam int OPT_NORED_BIT = 6;
	localparam logic [1:0] SEC_OPEN = 2'h2;
	localparam int PROT_DIS_BIT = 0;
	// Flash command codes flagged as an access error from debug while secure
	localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
	localparam logic [7:0] CMD_BURST_PROG = 8'h25;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
	// APB register offsets
	localparam logic [7:0] OFS_OPTION = 8'h00;
	localparam logic [7:0] OFS_PROT = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_DEBUG = 8'h10;
	// Config and status bit positions
	localparam int CFG_KEY_ACCESS_MODE_BIT = 5;
	localparam int ST_SECURE_BIT = 0;
	localparam int ST_REDIR_BIT = 1;
	localparam int ST_ACCERR_BIT = 2;
	localparam int ST_UNLOCK_BIT = 3;
	localparam int ST_BGND_BIT = 4;
	// Reset values
	localparam logic [7:0] OPT_RST = 8'h00;
	localparam logic [7:0] PROT_RST = 8'h01;
	// Controller states
	typedef enum logic [2:0] {
		ST_LOAD = 3'b001,
		ST_RUN = 3'b010,
		ST_CMP = 3'b100
	} fsv_state_t;
endpackage : fsv_pkg

// ### verilog/fsv_key_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Entered key byte store with registered read
// ----------------------------------------------------------------------------
module fsv_key_mem (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Write port
	input wire logic wr_i,
	input wire logic [2:0] waddr_i,
	input wire logic [7:0] wdata_i,
	// Read port
	input wire logic [2:0] raddr_i,
	output logic [7:0] rdata_o
);
	import fsv_pkg::*;

	typedef struct packed {
		logic [KEY_BYTES-1:0][7:0] mem;
		logic [7:0] rdata;
	} fsv_mem_t;

	fsv_mem_t s_reg;
	fsv_mem_t s_next;

	// Write and read next state
	always_comb begin
		s_next = s_reg;
		for (int i = 0; i < KEY_BYTES; i++) begin
			if (wr_i && (waddr_i == i[2:0])) begin
				s_next.mem[i] = wdata_i;
			end
		end
		s_next.rdata = s_reg.mem[raddr_i];
	end

	// State register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign rdata_o = s_reg.rdata;

	// Written byte becomes readable
	mem_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		ce_i && wr_i ##1 ce_i && raddr_i == $past(waddr_i) ##1 1'b1
		|-> (!ce_i) || (rdata_o == $past(wdata_i, 2)) || $past(wr_i))
		else $error("key byte not stored");
endmodule : fsv_key_mem
`default_nettype wire

// ### verilog/fsv_zz_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### sim/fsv_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// CPU, debug controller and memory at the far side of the access path
// ----------------------------------------------------------------------------
module fsv_bus_model (
	// Clock
	input wire logic clk_i,
	// Memory side of the block
	input wire logic mem_req_i,
	input wire logic [15:0] mem_addr_i,
	output logic [7:0] mem_rdata_o,
	// Access requests towards the block
	output logic acc_valid_o,
	output logic acc_write_o,
	output logic [15:0] acc_addr_o,
	output logic [7:0] acc_wdata_o,
	output logic acc_vector_o,
	output logic acc_secure_o,
	output logic acc_ram_o,
	output logic acc_debug_o
);
	// Idle bus at time zero
	initial begin
		mem_rdata_o = 8'h00;
		acc_valid_o = 1'b0;
		{acc_write_o, acc_addr_o, acc_wdata_o} = 25'h000_0000;
		{acc_vector_o, acc_secure_o, acc_ram_o, acc_debug_o} = 4'h0;
	end

	// Read data only in the cycle after a request, a toggling pattern otherwise
	always @(posedge clk_i) begin
		if (mem_req_i) begin
			mem_rdata_o <= mem_addr_i[7:0] ^ mem_addr_i[15:8];
		end else begin
			mem_rdata_o <= ~mem_rdata_o;
		end
	end

	// One strobe: raised after an edge, taken at the next, then dropped
	task automatic issue(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [3:0] k);
		@(posedge clk_i);
		acc_valid_o <= 1'b1;
		{acc_write_o, acc_addr_o, acc_wdata_o} <= {w, a, d};
		{acc_vector_o, acc_secure_o, acc_ram_o, acc_debug_o} <= k;
		@(posedge clk_i);
		acc_valid_o <= 1'b0;
	endtask : issue
endmodule : fsv_bus_model
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fsv_pkg::*;
	// ------------------------------------------------------------------------
	// Signals, design and far side
	// ------------------------------------------------------------------------
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pdebug_i = 1'b0;
	logic [7:0] paddr_i = 8'h00, nv_option_byte_i = 8'h00, nv_protection_byte_i = 8'h00, fcmd_code_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, seed = 32'h0001_410B;
	logic [63:0] backdoor_key_bytes_i = 64'h0;
	logic background_mode_pin_i = 1'b1, bgnd_req_i = 1'b0, fcmd_wr_i = 1'b0, fcmd_debug_i = 1'b0, blank_ok_i = 1'b0;
	logic acc_valid_i, acc_write_i, acc_vector_i, acc_secure_code_i, acc_ram_code_i, acc_debug_i;
	logic [15:0] acc_addr_i, mem_addr_o;
	logic [7:0] acc_wdata_i, mem_rdata_i, mem_wdata_o, acc_rdata_o;
	logic pready_o, pslverr_o, bgnd_active_o, mem_req_o, mem_write_o, acc_blocked_o, secure_o, debug_en_o;
	logic [7:0] red_opt [5] = '{8'h02, 8'h42, 8'h02, 8'h02, 8'h02};
	logic [7:0] red_prot [5] = '{8'hFC, 8'hFC, 8'hFD, 8'hBE, 8'hFE};
	logic [7:0] cmds [5] = '{8'h05, CMD_BYTE_PROG, CMD_BURST_PROG, CMD_PAGE_ERASE, 8'h41};
	int failures = 0;
	int tests_run = 0;

	fsv_ctrl dut (
		.clk_i, .nrst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pdebug_i,
		.prdata_o, .pready_o, .pslverr_o, .nv_option_byte_i, .nv_protection_byte_i, .backdoor_key_bytes_i,
		.background_mode_pin_i, .bgnd_req_i, .bgnd_active_o, .acc_valid_i, .acc_write_i, .acc_addr_i,
		.acc_wdata_i, .acc_vector_i, .acc_secure_code_i, .acc_ram_code_i, .acc_debug_i, .mem_req_o,
		.mem_write_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .acc_rdata_o, .acc_blocked_o, .fcmd_wr_i,
		.fcmd_code_i, .fcmd_debug_i, .blank_ok_i, .secure_o, .debug_en_o
	);
	fsv_bus_model bus (
		.clk_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i),
		.acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i), .acc_addr_o(acc_addr_i), .acc_wdata_o(acc_wdata_i),
		.acc_vector_o(acc_vector_i), .acc_secure_o(acc_secure_code_i), .acc_ram_o(acc_ram_code_i),
		.acc_debug_o(acc_debug_i)
	);

	// 250 MHz clock
	always #2 clk_i = ~clk_i;

	// ------------------------------------------------------------------------
	// Reference model, compares and bus tasks
	// ------------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	// Blocked when secure, target is flash or RAM, and caller is debug or unsecured code
	function automatic logic blk(input logic sec, input logic [15:0] a, input logic [3:0] k);
		int ad;
		ad = a;
		return sec && (ad >= FLASH_LO || (ad >= RAM_LO && ad <= RAM_HI)) && (k[0] || !k[2]);
	endfunction : blk

	task automatic chk_flag(input logic g, input logic e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t flag got %b expected %b", $time, g, e);
		end
	endtask : chk_flag

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t value got %h expected %h", $time, g, e);
		end
	endtask : chk_val

	task automatic tally_and_finish();
		$display("Compares %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// APB transfer: setup, access, wait for pready, then release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic dbg,
		output logic [31:0] q, output logic err);
		int n = 0;
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, pdebug_i, paddr_i, pwdata_i} <= {2'b10, w, dbg, a, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		q = prdata_o;
		err = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
		if (n >= 50) chk_flag(1'b0, 1'b1);
	endtask : apb

	// Reset with new stored bytes and strap, then check the loaded security state
	task automatic do_reset(input logic [7:0] o, input logic [7:0] p, input logic bp);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		{nv_option_byte_i, nv_protection_byte_i, background_mode_pin_i} <= {o, p, bp};
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1 chk_flag(secure_o, o[1:0] != SEC_OPEN);
	endtask : do_reset

	// One access through the far side with every result compared
	task automatic access(input logic w, input logic [15:0] a, input logic [3:0] k, input logic eb,
		input logic [15:0] ea);
		logic [7:0] d;
		d = rnd();
		bus.issue(w, a, d, k);
		#1 chk_flag(acc_blocked_o, eb);
		chk_flag(mem_req_o, !eb);
		if (!eb) chk_val({mem_write_o, mem_addr_o}, {w, ea});
		if (!eb && w) chk_val(mem_wdata_o, d);
		// Memory answers a cycle after the request, the block registers it once more
		repeat (2) @(posedge clk_i);
		#1 if (!w) chk_val(acc_rdata_o, eb ? 8'h00 : ea[7:0] ^ ea[15:8]);
	endtask : access

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic e;
		logic [15:0] a;
		logic [15:0] lu;
		logic r;
		int i;
		int j;
		// Every security field value with and without the strap
		bgnd_req_i <= 1'b1;
		for (i = 0; i < 8; i++) begin
			do_reset({6'h00, i[1:0]}, 8'hFF, i[2]);
			apb(1'b1, OFS_DEBUG, 32'h0000_0001, 1'b0, q, e);
			apb(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0, q, e);
			chk_flag(q[ST_SECURE_BIT], i[1:0] != SEC_OPEN);
			chk_flag(debug_en_o, i[1:0] == SEC_OPEN);
			chk_flag(bgnd_active_o, !i[2] || i[1:0] == SEC_OPEN);
		end
		bgnd_req_i <= 1'b0;
		// Register loads, read-only option, debug-only protection, unmapped offset
		do_reset(8'h42, 8'hFF, 1'b1);
		apb(1'b1, OFS_OPTION, 32'h0000_00FF, 1'b1, q, e);
		apb(1'b0, OFS_OPTION, 32'h0000_0000, 1'b0, q, e);
		chk_val(q, 32'h0000_0042);
		apb(1'b1, OFS_PROT, 32'h0000_00FC, 1'b0, q, e);
		apb(1'b0, OFS_PROT, 32'h0000_0000, 1'b0, q, e);
		chk_val(q, 32'h0000_00FF);
		apb(1'b1, OFS_PROT, 32'h0000_00FC, 1'b1, q, e);
		apb(1'b0, OFS_PROT, 32'h0000_0000, 1'b0, q, e);
		chk_val(q, 32'h0000_00FC);
		apb(1'b0, 8'h20, 32'h0000_0000, 1'b0, q, e);
		chk_val({e, q}, {1'b1, 32'h0000_0000});
		// Vector redirection over option and protection settings
		for (i = 0; i < 5; i++) begin
			do_reset(red_opt[i], red_prot[i], 1'b1);
			lu = {red_prot[i][7:1], 9'h1FF};
			r = !red_opt[i][OPT_NORED_BIT] && !red_prot[i][PROT_DIS_BIT] && lu >= FLASH_LO && lu != 16'hFFFF;
			apb(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0, q, e);
			chk_flag(q[ST_REDIR_BIT], r);
			access(1'b0, VEC_HI, 4'b1100, 1'b0, r ? {red_prot[i][7:1], VEC_HI[8:0]} : VEC_HI);
			access(1'b0, 16'hFFFE, 4'b1100, 1'b0, 16'hFFFE);
		end
		// Secure blocking: two fixed unguarded addresses and RAM_HI first, then random traffic
		do_reset(8'hC3, 8'hFF, 1'b1);
		for (i = 0; i < 24; i++) begin
			q = rnd();
			a = (i == 0) ? 16'h0040 : (i == 1) ? 16'h1820 : (i == 2) ? RAM_HI : q[15:0];
			access(q[19], a, {1'b0, q[18:16]}, blk(1'b1, a, {1'b0, q[18:16]}), a);
		end
		// Key unlock: good key, wrong last byte, unlock disabled, debug entry
		for (i = 0; i < 4; i++) begin
			backdoor_key_bytes_i <= {rnd(), rnd()};
			do_reset(i == 2 ? 8'h43 : 8'hC3, 8'hFF, 1'b1);
			apb(1'b1, OFS_CONFIG, 32'h0000_0020, 1'b0, q, e);
			// Ascending key order, one idle cycle between strobes
			for (j = 0; j < KEY_BYTES; j++) begin
				bus.issue(1'b1, KEY_BASE_ADDR + j[15:0], backdoor_key_bytes_i[8*j +: 8] ^ {7'h00, i == 1 && j == 7},
					i == 3 ? 4'b0001 : 4'b0110);
				#1 chk_flag(mem_req_o && mem_write_o, 1'b0);
			end
			apb(1'b1, OFS_CONFIG, 32'h0000_0000, 1'b0, q, e);
			repeat (12) @(posedge clk_i);
			#1 chk_flag(secure_o, i != 0);
			apb(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0, q, e);
			chk_flag(q[ST_UNLOCK_BIT], i == 0);
		end
		// Debug flash commands while secure, then a clean blank check
		do_reset(8'h03, 8'hFF, 1'b1);
		for (i = 0; i < 5; i++) begin
			@(posedge clk_i);
			{fcmd_wr_i, fcmd_code_i, fcmd_debug_i} <= {1'b1, cmds[i], 1'b1};
			@(posedge clk_i);
			fcmd_wr_i <= 1'b0;
			apb(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0, q, e);
			chk_flag(q[ST_ACCERR_BIT], i >= 1 && i <= 3);
			apb(1'b1, OFS_STATUS, 32'h0000_0004, 1'b0, q, e);
		end
		// A blank check pulse while the clock enable is low must leave the device secure
		@(posedge clk_i);
		ce_i <= 1'b0;
		blank_ok_i <= 1'b1;
		@(posedge clk_i);
		blank_ok_i <= 1'b0;
		#1 chk_flag(secure_o, 1'b1);
		@(posedge clk_i);
		ce_i <= 1'b1;
		blank_ok_i <= 1'b1;
		@(posedge clk_i);
		blank_ok_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk_flag(secure_o, 1'b0);
		tally_and_finish();
	end

	// Watchdog, far above the several hundred cycles the run needs
	initial begin
		#200000;
		failures++;
		$display("BAD t=%0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
